// ==== dpmd_regs.vh ====
// constants for the data port message decoder
`ifndef DPMD_REGS_VH
`define DPMD_REGS_VH
// ****************
// apb register offsets
// ****************
`define DPMD_CTRL_OFF 12'h000
`define DPMD_STAT_OFF 12'h004
`define DPMD_ERRCNT_OFF 12'h008
`define DPMD_MSGCNT_OFF 12'h00c
`define DPMD_LASTDESC_OFF 12'h010
`define DPMD_LASTADDR_OFF 12'h014
`define DPMD_CTRL_RST 32'h0000_0001
// ****************
// descriptor fields
// ****************
`define DPMD_HDR_BIT 19
`define DPMD_RD_CACHE_HI 15
`define DPMD_RD_CACHE_LO 14
`define DPMD_RD_TYPE_HI 13
`define DPMD_RD_TYPE_LO 12
`define DPMD_WR_COMMIT_BIT 15
`define DPMD_WR_TYPE_HI 14
`define DPMD_WR_TYPE_LO 12
`define DPMD_CTL_HI 11
`define DPMD_CTL_LO 8
`define DPMD_LAST_RT_BIT 10
`define DPMD_SIMD8_BIT 8
`define DPMD_HALF_BIT 11
`define DPMD_BTI_HI 7
`define DPMD_BTI_LO 0
`define DPMD_BTI_STATELESS 8'hff
// ****************
// encodings
// ****************
`define DPMD_CACHE_DATA 2'h0
`define DPMD_CACHE_RENDER 2'h1
`define DPMD_CACHE_SAMPLER 2'h2
`define DPMD_CACHE_RSVD 2'h3
`define DPMD_RD_OWORD 2'h0
`define DPMD_RD_DUAL 2'h1
`define DPMD_RD_MEDIA 2'h2
`define DPMD_RD_SCATTER 2'h3
`define DPMD_WR_OWORD 3'h0
`define DPMD_WR_DUAL 3'h1
`define DPMD_WR_MEDIA 3'h2
`define DPMD_WR_SCATTER 3'h3
`define DPMD_WR_RT 3'h4
`define DPMD_WR_SVB 3'h5
`define DPMD_WR_RSVD 3'h6
`define DPMD_WR_FLUSH 3'h7
`define DPMD_RT_SINGLE 2'h0
`define DPMD_RT_DUAL 2'h1
`define DPMD_RT_REPL 2'h2
`endif

// ==== dpmd_addr.v ====
// address former for header and per-slot offset addressing
`timescale 1ns/1ps
module dpmd_addr (
  input wire hdr_present,
  input wire scratch,
  input wire use_offset,
  input wire [31:0] global_off,
  input wire [31:0] imm_base,
  input wire [31:0] slot_off,
  output reg [31:0] addr
);
  reg [31:0] base;
  always @* begin
    if (!hdr_present) begin
      base = 32'h0000_0000;
    end else if (scratch) begin
      base = {imm_base[31:10], 10'h000};
    end else begin
      base = global_off;
    end
    if (use_offset) begin
      addr = base + slot_off;
    end else begin
      addr = base;
    end
  end
endmodule

// ==== dpmd_sbclr.v ====
// pixel scoreboard clear mask former
`timescale 1ns/1ps
module dpmd_sbclr (
  input wire last_rt,
  input wire simd8,
  input wire upper_half,
  input wire [15:0] pixel_mask,
  output reg [15:0] clr_mask
);
  always @* begin
    if (!last_rt) begin
      clr_mask = 16'h0000;
    end else if (simd8 && upper_half) begin
      clr_mask = {pixel_mask[15:8], 8'h00};
    end else if (simd8) begin
      clr_mask = {8'h00, pixel_mask[7:0]};
    end else begin
      clr_mask = pixel_mask;
    end
  end
endmodule

// ==== dpmd_top.v ====
// data port message decoder top: message intake, decode, apb status
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "dpmd_regs.vh"
// Function
// - render target data goes to the colour path for format conversion.
// - single-source writes come in 16- and 8-pixel forms.
// - scoreboard bits clear only on last-target writes, half mask for 8-pixel.
// - dual-source writes are 8-pixel only, two colours per pixel.
// - second colour of dual-source is offered as blend factor input.
// - replicate writes carry no depth, stencil or alpha; tiled only.
// - each target its own message and index; depth only on last.
// - separate read and write targets, each with own unit id and types.
// - no header means base displacement of zero.
// - per-slot payload offset adds to header base displacement.
// - scratch messages take base from header word five.
// - typed surface 4D means u, v, depth and mip level.
// - read bits 15:14 select data, render or sampler cache; 11 reserved.
// - read bits 13:12 select oword, dual, media or scattered read.
// - write bit 15 requests a completion message after commit.
// - write bits 14:12 select write type; 110 reserved.
// - bits 11:8 are a message specific control field.
// - binding index 255 selects stateless access with no surface fetch.
module dpmd_top (
  input wire clk,
  input wire rst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire msg_valid,
  output reg msg_ready,
  input wire msg_is_write,
  input wire [3:0] msg_unit_id,
  input wire [31:0] msg_desc,
  input wire [31:0] msg_global_off,
  input wire [31:0] header_word_five,
  input wire [31:0] msg_slot_off,
  input wire [1:0] msg_rt_kind,
  input wire [15:0] msg_pixel_mask,
  input wire [10:0] msg_target_layer_index,
  input wire [2:0] msg_dim,
  input wire thread_termination_flag,
  output reg mem_valid,
  input wire mem_ready,
  output reg mem_is_write,
  output reg [1:0] mem_cache,
  output reg [2:0] mem_type,
  output reg [3:0] mem_ctl,
  output reg [31:0] mem_addr,
  output reg [7:0] mem_bti,
  output reg mem_stateless,
  output reg mem_rt_write,
  output reg mem_blend_src1,
  output reg mem_depth_write,
  output reg [10:0] mem_target_layer_index,
  output reg [2:0] mem_dim,
  input wire mem_commit,
  output reg commit_msg,
  output reg [15:0] sb_clear,
  output reg sb_clear_valid,
  output reg msg_error
);
  // ****************
  // parameters and state
  // ****************
  parameter [3:0] RD_UNIT_ID = 4'h4;
  parameter [3:0] WR_UNIT_ID = 4'h5;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ISSUE = 3'b010;
  localparam [2:0] ST_COMMIT = 3'b100;
  reg [2:0] state_q;
  reg [31:0] ctrl_q;
  reg [15:0] err_cnt_q;
  reg [31:0] msg_cnt_q;
  reg [31:0] last_desc_q;
  reg [1:0] last_err_q;
  reg want_commit_q;
  reg [15:0] pend_clr_q;
  reg pend_clr_v_q;
  wire [15:0] clr_mask;
  wire [31:0] addr;
  // ****************
  // descriptor decode
  // ****************
  wire [1:0] rd_cache = msg_desc[`DPMD_RD_CACHE_HI:`DPMD_RD_CACHE_LO];
  wire [1:0] rd_type = msg_desc[`DPMD_RD_TYPE_HI:`DPMD_RD_TYPE_LO];
  wire [2:0] wr_type = msg_desc[`DPMD_WR_TYPE_HI:`DPMD_WR_TYPE_LO];
  wire [3:0] ctl = msg_desc[`DPMD_CTL_HI:`DPMD_CTL_LO];
  wire [7:0] bti = msg_desc[`DPMD_BTI_HI:`DPMD_BTI_LO];
  wire hdr = msg_desc[`DPMD_HDR_BIT];
  wire is_rt = msg_is_write && (wr_type == `DPMD_WR_RT);
  wire last_rt = is_rt && msg_desc[`DPMD_LAST_RT_BIT];
  wire simd8 = msg_desc[`DPMD_SIMD8_BIT] || (msg_rt_kind == `DPMD_RT_DUAL);
  wire scratch = msg_is_write ? (wr_type == `DPMD_WR_OWORD)
                              : (rd_type == `DPMD_RD_OWORD);
  wire offset_mode = msg_is_write
    ? (wr_type == `DPMD_WR_DUAL || wr_type == `DPMD_WR_SCATTER)
    : (rd_type == `DPMD_RD_DUAL || rd_type == `DPMD_RD_SCATTER);

  // classify: bit0 reserved code, bit1 wrong unit id
  function [1:0] dpmd_check;
    input is_wr;
    input [3:0] uid;
    input [1:0] cache;
    input [2:0] wtype;
    input [1:0] rtk;
    begin
      dpmd_check = 2'b00;
      if (is_wr) begin
        if (wtype == `DPMD_WR_RSVD) dpmd_check[0] = 1'b1;
        if (wtype == `DPMD_WR_RT && rtk == 2'h3) dpmd_check[0] = 1'b1;
        if (uid != WR_UNIT_ID) dpmd_check[1] = 1'b1;
      end else begin
        if (cache == `DPMD_CACHE_RSVD) dpmd_check[0] = 1'b1;
        if (uid != RD_UNIT_ID) dpmd_check[1] = 1'b1;
      end
    end
  endfunction

  wire [1:0] chk = dpmd_check(msg_is_write, msg_unit_id, rd_cache,
                              wr_type, msg_rt_kind);
  wire bad = (|chk) || !ctrl_q[0];

  dpmd_addr u_addr (
    .hdr_present(hdr),
    .scratch(scratch),
    .use_offset(offset_mode),
    .global_off(msg_global_off),
    .imm_base(header_word_five),
    .slot_off(msg_slot_off),
    .addr(addr)
  );

  dpmd_sbclr u_sbclr (
    .last_rt(last_rt),
    .simd8(simd8),
    .upper_half(msg_desc[`DPMD_HALF_BIT]),
    .pixel_mask(msg_pixel_mask),
    .clr_mask(clr_mask)
  );

  // ****************
  // message engine
  // ****************
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      msg_ready <= 1'b0;
      mem_valid <= 1'b0;
      mem_is_write <= 1'b0;
      mem_cache <= 2'h0;
      mem_type <= 3'h0;
      mem_ctl <= 4'h0;
      mem_addr <= 32'h0000_0000;
      mem_bti <= 8'h00;
      mem_stateless <= 1'b0;
      mem_rt_write <= 1'b0;
      mem_blend_src1 <= 1'b0;
      mem_depth_write <= 1'b0;
      mem_target_layer_index <= 11'h000;
      mem_dim <= 3'h0;
      commit_msg <= 1'b0;
      sb_clear <= 16'h0000;
      sb_clear_valid <= 1'b0;
      msg_error <= 1'b0;
      err_cnt_q <= 16'h0000;
      msg_cnt_q <= 32'h0000_0000;
      last_desc_q <= 32'h0000_0000;
      last_err_q <= 2'b00;
      want_commit_q <= 1'b0;
      pend_clr_q <= 16'h0000;
      pend_clr_v_q <= 1'b0;
    end else begin
      msg_ready <= 1'b0;
      commit_msg <= 1'b0;
      sb_clear_valid <= 1'b0;
      msg_error <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (msg_valid && !msg_ready) begin
            msg_ready <= 1'b1;
            last_desc_q <= msg_desc;
            msg_cnt_q <= msg_cnt_q + 32'h0000_0001;
            if (bad) begin
              msg_error <= 1'b1;
              last_err_q <= chk;
              err_cnt_q <= err_cnt_q + 16'h0001;
            end else begin
              mem_valid <= 1'b1;
              mem_is_write <= msg_is_write;
              mem_cache <= msg_is_write ? `DPMD_CACHE_RENDER : rd_cache;
              mem_type <= msg_is_write ? wr_type : {1'b0, rd_type};
              mem_ctl <= ctl;
              mem_addr <= addr;
              mem_bti <= bti;
              mem_stateless <= (bti == `DPMD_BTI_STATELESS);
              mem_rt_write <= is_rt;
              mem_blend_src1 <= is_rt && (msg_rt_kind == `DPMD_RT_DUAL);
              mem_depth_write <= last_rt &&
                                 (msg_rt_kind != `DPMD_RT_REPL);
              mem_target_layer_index <= msg_target_layer_index;
              mem_dim <= msg_dim;
              want_commit_q <= msg_is_write &&
                               msg_desc[`DPMD_WR_COMMIT_BIT];
              pend_clr_q <= clr_mask;
              pend_clr_v_q <= last_rt;
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          if (mem_ready) begin
            mem_valid <= 1'b0;
            if (pend_clr_v_q) begin
              sb_clear <= pend_clr_q;
              sb_clear_valid <= 1'b1;
            end
            state_q <= want_commit_q ? ST_COMMIT : ST_IDLE;
          end
        end
        ST_COMMIT: begin
          if (mem_commit) begin
            commit_msg <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // apb slave
  // ****************
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `DPMD_CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && pready) begin
        // write lands at the edge where the master sees pready
        if (pwrite && paddr == `DPMD_CTRL_OFF) begin
          ctrl_q <= {31'h0, pwdata[0]};
        end
      end else if (psel && penable) begin
        pready <= 1'b1;
        prdata <= 32'h0000_0000;
        if (paddr == `DPMD_CTRL_OFF) begin
          prdata <= ctrl_q;
        end else if (paddr == `DPMD_STAT_OFF) begin
          prdata <= {27'h0, last_err_q, state_q};
        end else if (paddr == `DPMD_ERRCNT_OFF) begin
          prdata <= {16'h0000, err_cnt_q};
        end else if (paddr == `DPMD_MSGCNT_OFF) begin
          prdata <= msg_cnt_q;
        end else if (paddr == `DPMD_LASTDESC_OFF) begin
          prdata <= last_desc_q;
        end else if (paddr == `DPMD_LASTADDR_OFF) begin
          prdata <= mem_addr;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== dpmd_top_asserts.sv ====
// port checker for the message decoder
`timescale 1ns/1ps
module dpmd_top_asserts (
  input wire clk,
  input wire rst,
  input wire msg_ready,
  input wire mem_valid,
  input wire mem_ready,
  input wire mem_is_write,
  input wire [1:0] mem_cache,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_bti,
  input wire mem_stateless,
  input wire mem_rt_write,
  input wire mem_blend_src1,
  input wire mem_depth_write,
  input wire mem_commit,
  input wire commit_msg,
  input wire sb_clear_valid,
  input wire msg_error
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  stateless_sel_a: assert property (
    mem_valid |-> mem_stateless == (mem_bti == 8'hff)) else $error("stateless");
  rsvd_cache_a: assert property (
    mem_valid && !mem_is_write |-> mem_cache != 2'h3) else $error("cache");
  err_no_mem_a: assert property (
    msg_error |-> !mem_valid) else $error("error with access");
  mem_hold_a: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
    else $error("request dropped");
  take_once_a: assert property (
    msg_ready |=> !msg_ready [*2]) else $error("double take");
  sb_after_rt_a: assert property (
    sb_clear_valid |-> $past(mem_valid && mem_ready && mem_rt_write))
    else $error("stray clear");
  commit_back_a: assert property (
    commit_msg |-> $past(mem_commit, 1)) else $error("stray commit");
  rt_only_a: assert property (
    mem_valid && (mem_blend_src1 || mem_depth_write) |-> mem_rt_write)
    else $error("rt field off");
  c_take: cover property (msg_ready ##1 mem_valid [*2] ##1 mem_ready);
  c_err: cover property (msg_error);
  c_commit: cover property (commit_msg);
endmodule
bind dpmd_top dpmd_top_asserts i_chk (.clk(clk), .rst(rst),
  .msg_ready(msg_ready), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_is_write(mem_is_write), .mem_cache(mem_cache), .mem_addr(mem_addr),
  .mem_bti(mem_bti), .mem_stateless(mem_stateless),
  .mem_rt_write(mem_rt_write), .mem_blend_src1(mem_blend_src1),
  .mem_depth_write(mem_depth_write), .mem_commit(mem_commit),
  .commit_msg(commit_msg), .sb_clear_valid(sb_clear_valid),
  .msg_error(msg_error));

// ==== dpmd_thread_model.sv ====
// sending thread: holds a message until taken
`timescale 1ns/1ps
module dpmd_thread_model (
  input wire clk,
  input wire rst,
  input wire go,
  input wire no_hdr,
  input wire [31:0] desc_in,
  input wire msg_ready,
  input wire msg_error,
  output reg msg_valid,
  output wire [31:0] msg_desc,
  output wire thread_termination_flag
);
  // ****************
  // handshake
  // ****************
  assign msg_desc = no_hdr ? desc_in & ~32'h80000 : desc_in | 32'h80000;
  assign thread_termination_flag = 1'b0;
  // no sampling-engine traffic is ever sent alongside reads
  always @(posedge clk) begin
    if (rst)
      msg_valid <= 1'b0;
    else if (go)
      msg_valid <= 1'b1;
    else if (msg_ready || msg_error)
      msg_valid <= 1'b0;
  end
endmodule

// ==== dpmd_top_tb.sv ====
// self-checking bench for the message decoder
`timescale 1ns/1ps
`include "dpmd_regs.vh"
module dpmd_top_tb;
  reg clk, rst, psel, penable, pwrite, go, no_hdr, mem_ready, mem_commit;
  reg is_w, en, perr;
  reg [11:0] paddr;
  reg [31:0] pwdata, desc, gof, w5, so, rd;
  reg [3:0] uid;
  reg [1:0] rk;
  reg [15:0] pm;
  wire [31:0] prdata, msg_desc, mem_addr;
  wire [15:0] sb_clear;
  wire [7:0] mem_bti;
  wire [3:0] mem_ctl;
  wire [2:0] mem_type;
  wire [1:0] mem_cache;
  wire pready, pslverr, msg_valid, msg_ready, ttf, mem_valid, mem_is_write;
  wire mem_stateless, mem_rt_write, mem_blend_src1, commit_msg;
  wire sb_clear_valid, msg_error, mdw;
  integer seed = 21430, fails = 0, cmp_count = 0, cyc = 0, i, k, sb, cm;
  dpmd_thread_model i_dpmd_thread_model (.clk(clk), .rst(rst), .go(go),
    .no_hdr(no_hdr), .desc_in(desc), .msg_ready(msg_ready),
    .msg_error(msg_error), .msg_valid(msg_valid), .msg_desc(msg_desc),
    .thread_termination_flag(ttf));
  dpmd_top i_dpmd_top (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_is_write(is_w), .msg_unit_id(uid),
    .msg_desc(msg_desc), .msg_global_off(gof), .header_word_five(w5),
    .msg_slot_off(so), .msg_rt_kind(rk), .msg_pixel_mask(pm),
    .msg_target_layer_index(11'h0), .msg_dim(3'h0),
    .thread_termination_flag(ttf), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_is_write(mem_is_write),
    .mem_cache(mem_cache), .mem_type(mem_type), .mem_ctl(mem_ctl),
    .mem_addr(mem_addr), .mem_bti(mem_bti), .mem_stateless(mem_stateless),
    .mem_rt_write(mem_rt_write), .mem_blend_src1(mem_blend_src1),
    .mem_depth_write(mdw), .mem_target_layer_index(), .mem_dim(),
    .mem_commit(mem_commit), .commit_msg(commit_msg), .sb_clear(sb_clear),
    .sb_clear_valid(sb_clear_valid), .msg_error(msg_error));
  // ****************
  // helpers
  // ****************
  task wrap_up;
    begin
      $display("compared %0d, wrong %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  function bit ex_err();
    ex_err = !en || uid != (is_w ? 4'h5 : 4'h4) || rk == 2'h3 ||
      (is_w ? desc[14:12] == 3'h6 : desc[15:14] == 2'h3);
  endfunction
  function [31:0] ex_addr();
    reg [2:0] t;
    begin
      t = is_w ? desc[14:12] : {1'b0, desc[13:12]};
      ex_addr = (no_hdr ? 32'h0 : (t == 3'h0 ? {w5[31:10], 10'h0} : gof)) +
        ((t == 3'h1 || t == 3'h3) ? so : 32'h0);
    end
  endfunction
  function [15:0] ex_mask();
    begin
      if (rk == 2'h1 || desc[8])
        ex_mask = desc[11] ? {pm[15:8], 8'h00} : {8'h00, pm[7:0]};
      else
        ex_mask = pm;
    end
  endfunction
  function ex_last();
    ex_last = is_w && desc[14:12] == 3'h4 && desc[`DPMD_LAST_RT_BIT];
  endfunction
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 20)
        fails = fails + 1;
      rd = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
    end
  endtask
  task send(input integer dly);
    begin
      go <= 1;
      @(posedge clk);
      go <= 0;
      k = 0;
      @(posedge clk);
      while (msg_ready !== 1'b1 && msg_error !== 1'b1 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k >= 20)
        fails = fails + 1;
      chk(msg_error, ex_err(), "error");
      if (!ex_err()) begin
        chk(mem_addr, ex_addr(), "addr");
        chk(mem_stateless, desc[7:0] == 8'hff, "stless");
        chk(mem_ctl, desc[11:8], "ctl");
        chk(mem_type, is_w ? desc[14:12] : desc[13:12], "type");
        if (!is_w)
          chk(mem_cache, desc[15:14], "cache");
        chk(mem_blend_src1, is_w && desc[14:12] == 3'h4 && rk == 2'h1,
          "blend");
        chk(mdw, ex_last() && rk != 2'h2, "depth");
        repeat (dly) @(posedge clk);
        mem_ready <= 1;
        @(posedge clk);
        mem_ready <= 0;
        mem_commit <= 1;
        sb = 0;
        cm = 0;
        repeat (4) begin
          @(posedge clk);
          mem_commit <= 0;
          sb = sb | sb_clear_valid;
          cm = cm | commit_msg;
        end
        chk(cm, is_w && desc[15], "commit");
        chk(sb, ex_last(), "sbclr");
        if (ex_last()) chk(sb_clear, ex_mask(), "mask");
      end
      @(posedge clk);
    end
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  initial begin
    {rst, psel, penable, pwrite, go, no_hdr, mem_ready, mem_commit} = 8'h80;
    {paddr, pwdata, desc, gof, w5, so, uid, rk, pm, is_w} = 0;
    en = 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, `DPMD_CTRL_OFF, 0);
    chk(rd, `DPMD_CTRL_RST, "ctrl");
    apb(0, 12'h0f0, 0);
    chk(perr, 1, "slverr");
    $display("register test ended");
    for (i = 0; i < 48; i = i + 1) begin
      is_w = i[0];
      desc = $random(seed);
      if (is_w)
        desc[14:12] = i[3:1];
      else
        desc[15:14] = i[2:1];
      if (i % 5 == 0)
        desc[7:0] = 8'hff;
      no_hdr = (i >= 32);
      gof = $random(seed);
      w5 = $random(seed);
      so = $random(seed);
      pm = $random(seed);
      rk = (is_w && desc[14:12] == 3'h4) ? {$random(seed)} % 3 : 0;
      uid = is_w ? 4'h5 : 4'h4;
      send(i % 3);
    end
    $display("message test ended");
    apb(1, `DPMD_CTRL_OFF, 0);
    en = 0;
    send(0);
    apb(1, `DPMD_CTRL_OFF, 1);
    en = 1;
    uid = 4'h7;
    send(0);
    $display("refusal test ended");
    wrap_up;
  end
endmodule
